/* File: hw/tsp_pkg.sv */
package tsp_pkg;

	// Clock and timing
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned BID_DELAY_MS = 1000;
	localparam int unsigned BID_DELAY_CYC = CLK_HZ / 1000 * BID_DELAY_MS;

	// Register byte offsets
	localparam logic [7:0] CFG_OFF = 8'h00;
	localparam logic [7:0] STAT_OFF = 8'h04;
	localparam logic [7:0] CMD_OFF = 8'h08;

	// Configuration fields
	localparam int CFG_LVL_LSB = 0;
	localparam int CFG_UCI_LSB = 4;
	localparam int CFG_SYNC_BIT = 8;
	localparam int CFG_HDR_LSB = 16;
	localparam logic [31:0] CFG_RST = 32'h0000_0003;
	localparam logic [31:0] CFG_MASK = 32'h001f_01f3;
	localparam logic [3:0] BASE_CODE_LEVEL = 4'h5;

	// Status bits
	localparam int ST_HALT = 0;
	localparam int ST_BID = 1;
	localparam int ST_BID_REQ = 2;
	localparam int ST_ONLINE = 3;
	localparam int ST_SUPPRESS = 4;
	localparam int ST_MOTOR = 5;
	localparam int ST_VERIFY = 6;
	localparam int ST_FEED = 7;
	localparam int ST_EXT = 8;
	localparam int ST_ABNORMAL = 9;
	localparam int ST_TAPE = 10;

	// Command bits
	localparam int CMD_ALM_CLR = 0;

	// Synchronised input indices
	localparam int IN_HALT = 0;
	localparam int IN_STEP = 1;
	localparam int IN_BID = 2;
	localparam int IN_DELETE = 3;
	localparam int IN_MOTOR = 4;
	localparam int IN_ALM_RST = 5;
	localparam int IN_TAPE = 6;
	localparam int IN_ONLINE = 7;
	localparam int IN_EOS = 8;
	localparam int IN_EOT = 9;
	localparam int IN_ABNORMAL = 10;
	localparam int IN_VERIFY = 11;
	localparam int IN_FEED = 12;
	localparam int IN_EXT = 13;
	localparam int IN_OTHER_HALT = 14;
	localparam int IN_STEP_PULSE = 15;
	localparam int IN_TXD = 16;
	localparam int NUM_IN = 17;

	typedef enum logic [2:0] {
		BID_IDLE = 3'b001,
		BID_WAIT = 3'b010,
		BID_REQ = 3'b100
	} tsp_bid_st_e;

endpackage : tsp_pkg

/* File: hw/tsp_sw_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface tsp_sw_if #(
	parameter int N = 1
);
	logic [N-1:0] lvl;
	logic [N-1:0] rise;

	modport src (output lvl, output rise);
	modport dst (input lvl, input rise);
endinterface : tsp_sw_if

`default_nettype wire

/* File: hw/tsp_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module tsp_sync #(
	parameter int N = 1
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Raw pins
	input wire logic [N-1:0] raw_i,
	// Clean levels and edges
	tsp_sw_if.src sw
);

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_bit
			logic meta_q;
			logic sync_q;
			logic prev_q;

			// Only sync_q reads meta_q
			always_ff @(posedge ref_clk_i) begin
				if (!rst_n_i) begin
					meta_q <= 1'b0;
					sync_q <= 1'b0;
					prev_q <= 1'b0;
				end else begin
					meta_q <= raw_i[g];
					sync_q <= meta_q;
					prev_q <= sync_q;
				end
			end

			assign sw.lvl[g] = sync_q;
			assign sw.rise[g] = sync_q & ~prev_q;
		end
	endgenerate

endmodule : tsp_sync

`default_nettype wire

/* File: hw/tsp_panel_ctrl.sv */
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module tsp_panel_ctrl #(
	parameter int unsigned BID_DELAY_CYC = tsp_pkg::BID_DELAY_CYC
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Operator switches
	input wire logic halt_sw_i,
	input wire logic step_sw_i,
	input wire logic bid_sw_i,
	input wire logic delete_sw_i,
	input wire logic motor_sw_i,
	input wire logic alarm_reset_sw_i,
	// Reader and external equipment
	input wire logic tape_present_i,
	input wire logic abnormal_i,
	input wire logic verify_alarm_i,
	input wire logic feed_alarm_i,
	input wire logic ext_alarm_i,
	input wire logic step_pulse_i,
	input wire logic txd_neutral_i,
	// Sequence control
	input wire logic online_i,
	input wire logic end_of_seq_i,
	input wire logic end_of_tx_i,
	input wire logic other_halt_i,
	output logic bid_req_o,
	output logic halt_others_o,
	output logic skip_header_o,
	// Reader drive
	output logic reader_run_o,
	output logic step_adv_o,
	output logic motor_run_o,
	output logic line_pos_o,
	// Lamps
	output logic halt_lamp_o,
	output logic online_lamp_o,
	output logic bid_lamp_o,
	output logic suppress_lamp_o,
	output logic motor_lamp_o,
	output logic abnormal_lamp_o,
	output logic verify_lamp_o,
	output logic feed_lamp_o,
	output logic ext_alarm_lamp_o,
	// Module settings
	output logic [3:0] code_level_o,
	output logic [3:0] char_interval_select_o,
	output logic sync_mode_o,
	output logic [4:0] header_char_bits_o
);

	tsp_sw_if #(.N(tsp_pkg::NUM_IN)) sw ();

	logic [tsp_pkg::NUM_IN-1:0] raw;
	assign raw = {txd_neutral_i, step_pulse_i, other_halt_i, ext_alarm_i,
		feed_alarm_i, verify_alarm_i, abnormal_i, end_of_tx_i, end_of_seq_i,
		online_i, tape_present_i, alarm_reset_sw_i, motor_sw_i, delete_sw_i,
		bid_sw_i, step_sw_i, halt_sw_i};

	tsp_sync #(.N(tsp_pkg::NUM_IN)) u_sync (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.raw_i(raw),
		.sw(sw)
	);

	logic online;
	logic tape;
	assign online = sw.lvl[tsp_pkg::IN_ONLINE];
	assign tape = sw.lvl[tsp_pkg::IN_TAPE];

	logic halt_q;
	logic bid_q;
	logic suppress_q;
	logic manual_q;
	logic verify_q;
	logic feed_q;
	logic ext_q;
	logic [31:0] cfg_q;
	logic [31:0] dly_q;
	logic alm_clr_sw;
	logic tape_out_clr;
	tsp_pkg::tsp_bid_st_e bid_st_q;

	// APB decode
	logic apb_setup;
	logic apb_wr;
	logic mapped;
	assign apb_setup = psel_i & ~penable_i;
	assign apb_wr = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
	assign mapped = (paddr_i == tsp_pkg::CFG_OFF) ||
		(paddr_i == tsp_pkg::STAT_OFF) || (paddr_i == tsp_pkg::CMD_OFF);

	logic [31:0] status;
	always_comb begin
		status = 32'h0000_0000;
		status[tsp_pkg::ST_HALT] = halt_q;
		status[tsp_pkg::ST_BID] = bid_q;
		status[tsp_pkg::ST_BID_REQ] = bid_req_o;
		status[tsp_pkg::ST_ONLINE] = online;
		status[tsp_pkg::ST_SUPPRESS] = suppress_q;
		status[tsp_pkg::ST_MOTOR] = motor_run_o;
		status[tsp_pkg::ST_VERIFY] = verify_q;
		status[tsp_pkg::ST_FEED] = feed_q;
		status[tsp_pkg::ST_EXT] = ext_q;
		status[tsp_pkg::ST_ABNORMAL] = abnormal_lamp_o;
		status[tsp_pkg::ST_TAPE] = tape;
	end

	// Answer is ready at the first access edge: one wait-free access phase
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end else begin
			pready_o <= apb_setup;
			pslverr_o <= apb_setup & ~mapped;
			if (apb_setup && !pwrite_i) begin
				if (paddr_i == tsp_pkg::CFG_OFF) begin
					prdata_o <= cfg_q;
				end else if (paddr_i == tsp_pkg::STAT_OFF) begin
					prdata_o <= status;
				end else begin
					prdata_o <= 32'h0000_0000;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			cfg_q <= tsp_pkg::CFG_RST;
		end else if (apb_wr && paddr_i == tsp_pkg::CFG_OFF) begin
			cfg_q <= pwdata_i & tsp_pkg::CFG_MASK;
		end
	end

	// Module settings
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			code_level_o <= tsp_pkg::BASE_CODE_LEVEL;
			char_interval_select_o <= 4'h0;
			sync_mode_o <= 1'b0;
			header_char_bits_o <= 5'h00;
		end else begin
			code_level_o <= tsp_pkg::BASE_CODE_LEVEL +
				{2'b00, cfg_q[tsp_pkg::CFG_LVL_LSB +: 2]};
			char_interval_select_o <= cfg_q[tsp_pkg::CFG_UCI_LSB +: 4];
			sync_mode_o <= cfg_q[tsp_pkg::CFG_SYNC_BIT];
			header_char_bits_o <= cfg_q[tsp_pkg::CFG_HDR_LSB +: 5];
		end
	end

	// Halt toggle
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			halt_q <= 1'b0;
		end else if (sw.rise[tsp_pkg::IN_HALT]) begin
			halt_q <= ~halt_q;
		end
	end

	// Halt holds the line on tape-out so the operator can edit and resume
	assign tape_out_clr = ~tape & ~halt_q &
		(~online | sw.lvl[tsp_pkg::IN_EOS]);

	// Bid flip-flop
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			bid_q <= 1'b0;
		end else if (bid_q && tape_out_clr) begin
			bid_q <= 1'b0;
		end else if (sw.rise[tsp_pkg::IN_BID]) begin
			if (!bid_q && tape) begin
				bid_q <= 1'b1;
			end else if (bid_q && !online) begin
				bid_q <= 1'b0;
			end
		end
	end

	// One-second delay from bid to request
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			bid_st_q <= tsp_pkg::BID_IDLE;
			dly_q <= 32'h0000_0000;
			bid_req_o <= 1'b0;
		end else begin
			case (bid_st_q)
				tsp_pkg::BID_IDLE: begin
					dly_q <= 32'h0000_0000;
					bid_req_o <= 1'b0;
					if (bid_q) begin
						bid_st_q <= tsp_pkg::BID_WAIT;
					end
				end
				tsp_pkg::BID_WAIT: begin
					dly_q <= dly_q + 32'h0000_0001;
					if (!bid_q) begin
						bid_st_q <= tsp_pkg::BID_IDLE;
					end else if (dly_q == 32'(BID_DELAY_CYC - 2)) begin
						bid_st_q <= tsp_pkg::BID_REQ;
						bid_req_o <= 1'b1;
					end
				end
				tsp_pkg::BID_REQ: begin
					if (!bid_q) begin
						bid_st_q <= tsp_pkg::BID_IDLE;
						bid_req_o <= 1'b0;
					end
				end
				default: begin
					bid_st_q <= tsp_pkg::BID_IDLE;
					bid_req_o <= 1'b0;
				end
			endcase
		end
	end

	// Manual motor run only while no bid is pending
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			manual_q <= 1'b0;
		end else if (bid_q) begin
			manual_q <= 1'b0;
		end else if (sw.rise[tsp_pkg::IN_MOTOR]) begin
			manual_q <= ~manual_q;
		end
	end

	// Header suppress; the end-of-transmission clear wins over a press
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			suppress_q <= 1'b0;
		end else if (sw.rise[tsp_pkg::IN_EOT]) begin
			suppress_q <= 1'b0;
		end else if (sw.rise[tsp_pkg::IN_DELETE] && !online) begin
			suppress_q <= ~suppress_q;
		end
	end

	// Alarms: a new alarm in the clearing cycle stays latched
	assign alm_clr_sw = sw.rise[tsp_pkg::IN_ALM_RST] |
		(apb_wr && paddr_i == tsp_pkg::CMD_OFF &&
		pwdata_i[tsp_pkg::CMD_ALM_CLR]);

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			verify_q <= 1'b0;
			feed_q <= 1'b0;
			ext_q <= 1'b0;
		end else begin
			verify_q <= sw.lvl[tsp_pkg::IN_VERIFY] |
				(verify_q & ~alm_clr_sw);
			feed_q <= sw.lvl[tsp_pkg::IN_FEED] |
				(feed_q & ~alm_clr_sw);
			ext_q <= sw.lvl[tsp_pkg::IN_EXT] |
				(ext_q & ~alm_clr_sw);
		end
	end

	// Registered outputs
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			reader_run_o <= 1'b0;
			step_adv_o <= 1'b0;
			motor_run_o <= 1'b0;
			line_pos_o <= 1'b0;
			halt_others_o <= 1'b0;
			skip_header_o <= 1'b0;
		end else begin
			reader_run_o <= online & ~halt_q &
				~sw.lvl[tsp_pkg::IN_OTHER_HALT];
			step_adv_o <= (sw.rise[tsp_pkg::IN_STEP] & halt_q) |
				(sw.rise[tsp_pkg::IN_STEP_PULSE] & online & ~halt_q &
				~sw.lvl[tsp_pkg::IN_OTHER_HALT]);
			motor_run_o <= bid_q | manual_q;
			line_pos_o <= sw.lvl[tsp_pkg::IN_TXD];
			halt_others_o <= halt_q;
			skip_header_o <= suppress_q;
		end
	end

	// Lamps
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			halt_lamp_o <= 1'b0;
			online_lamp_o <= 1'b0;
			bid_lamp_o <= 1'b0;
			suppress_lamp_o <= 1'b0;
			motor_lamp_o <= 1'b0;
			abnormal_lamp_o <= 1'b0;
			verify_lamp_o <= 1'b0;
			feed_lamp_o <= 1'b0;
			ext_alarm_lamp_o <= 1'b0;
		end else begin
			halt_lamp_o <= halt_q;
			online_lamp_o <= online;
			bid_lamp_o <= bid_q;
			suppress_lamp_o <= suppress_q;
			motor_lamp_o <= bid_q | manual_q;
			abnormal_lamp_o <= sw.lvl[tsp_pkg::IN_ABNORMAL];
			verify_lamp_o <= verify_q;
			feed_lamp_o <= feed_q;
			ext_alarm_lamp_o <= ext_q;
		end
	end

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_halt_toggle: assert property (
		sw.rise[tsp_pkg::IN_HALT] |=> halt_q != $past(halt_q) ##1
			halt_lamp_o == $past(halt_q))
		else $error("halt switch did not toggle halt and lamp");

	a_halt_blocks_run: assert property (
		halt_q || sw.lvl[tsp_pkg::IN_OTHER_HALT] |=> !reader_run_o)
		else $error("reader ran while a reader was halted");

	a_step_single: assert property (
		step_adv_o |-> $past(sw.rise[tsp_pkg::IN_STEP] && halt_q) ||
			$past(sw.rise[tsp_pkg::IN_STEP_PULSE] && !halt_q))
		else $error("step advance without a step cause");

	a_online_lamp: assert property (
		online_lamp_o == $past(online))
		else $error("on-line lamp did not follow grant");

	a_bid_tape: assert property (
		$rose(bid_q) |-> $past(tape) ##1 bid_lamp_o && motor_run_o)
		else $error("bid set without tape or lamp and motor not on");

	a_bid_delay: assert property (
		$rose(bid_req_o) |-> $past(dly_q) == 32'(BID_DELAY_CYC - 2) &&
			$past(bid_q))
		else $error("bid request not one second after bid");

	a_cancel_gate: assert property (
		$fell(bid_q) |-> $past(tape_out_clr) ||
			$past(sw.rise[tsp_pkg::IN_BID] && !online))
		else $error("bid cleared without a legal cause");

	a_suppress_clear: assert property (
		sw.rise[tsp_pkg::IN_EOT] |=> !suppress_q ##1 !suppress_lamp_o)
		else $error("suppress not cleared at end of transmission");

	a_alarm_hold: assert property (
		verify_q && !alm_clr_sw |=> verify_q)
		else $error("verify alarm lost without a reset");

	a_manual_motor: assert property (
		bid_q |=> !manual_q)
		else $error("manual motor latched while bid pending");

endmodule : tsp_panel_ctrl

`default_nettype wire

/* File: verif/tsp_seq_model.sv */
`timescale 1ns/1ps
`default_nettype none

module tsp_seq_model #(
	parameter int GRANT_DLY = 3,
	parameter int SEQ_LEN = 400
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Reader side
	input wire logic bid_req_i,
	input wire logic halt_others_i,
	input wire logic other_halt_i,
	input wire logic tx_done_i,
	output logic online_o,
	output logic end_of_seq_o,
	output logic end_of_tx_o
);
	int cnt_q;

	// Grant is withdrawn as soon as the bid goes away
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || !bid_req_i) begin
			online_o <= 1'b0;
			end_of_seq_o <= 1'b0;
			cnt_q <= 0;
		end else if (!online_o) begin
			if (halt_others_i || other_halt_i) begin
				cnt_q <= 0;
			end else if (cnt_q >= GRANT_DLY) begin
				online_o <= 1'b1;
				cnt_q <= 0;
			end else begin
				cnt_q <= cnt_q + 1;
			end
		end else begin
			cnt_q <= cnt_q + 1;
			end_of_seq_o <= (cnt_q >= SEQ_LEN);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		end_of_tx_o <= rst_n_i && tx_done_i;
	end
endmodule : tsp_seq_model

`default_nettype wire

/* File: verif/tb_tape_sender_panel_control.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_tape_sender_panel_control;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] pa = 8'h00;
	logic [31:0] pwd = 32'h0000_0000;
	logic [31:0] prd, rd, v;
	logic prdy, perr, err;
	// halt, step, bid, delete, motor, alarm reset
	logic [5:0] sw = 6'h00;
	logic [2:0] alm = 3'h0;
	logic tape = 1'b0;
	logic abn = 1'b0;
	logic txd = 1'b0;
	logic oth = 1'b0;
	logic spul = 1'b0;
	logic txdone = 1'b0;
	logic online, eos, eot, req, hoth, skip, run, stp, mrun, lpos, sync;
	logic [8:0] lamp;
	logic [3:0] lvl, uci;
	logic [4:0] hdr;
	int n_fail = 0;
	int cmp_count = 0;
	int n_step = 0;
	int s, t;

	tsp_panel_ctrl #(.BID_DELAY_CYC(20)) u_tsp_panel_ctrl (
		.ref_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
		.pready_o(prdy), .pslverr_o(perr), .halt_sw_i(sw[0]),
		.step_sw_i(sw[1]), .bid_sw_i(sw[2]), .delete_sw_i(sw[3]),
		.motor_sw_i(sw[4]), .alarm_reset_sw_i(sw[5]),
		.tape_present_i(tape), .abnormal_i(abn), .verify_alarm_i(alm[0]),
		.feed_alarm_i(alm[1]), .ext_alarm_i(alm[2]), .step_pulse_i(spul),
		.txd_neutral_i(txd), .online_i(online), .end_of_seq_i(eos),
		.end_of_tx_i(eot), .other_halt_i(oth), .bid_req_o(req),
		.halt_others_o(hoth), .skip_header_o(skip), .reader_run_o(run),
		.step_adv_o(stp), .motor_run_o(mrun), .line_pos_o(lpos),
		.halt_lamp_o(lamp[0]), .online_lamp_o(lamp[1]),
		.bid_lamp_o(lamp[2]), .suppress_lamp_o(lamp[3]),
		.motor_lamp_o(lamp[4]), .abnormal_lamp_o(lamp[5]),
		.verify_lamp_o(lamp[6]), .feed_lamp_o(lamp[7]),
		.ext_alarm_lamp_o(lamp[8]), .code_level_o(lvl),
		.char_interval_select_o(uci), .sync_mode_o(sync),
		.header_char_bits_o(hdr)
	);

	tsp_seq_model u_tsp_seq_model (
		.ref_clk_i(clk), .rst_n_i(rst_n), .bid_req_i(req),
		.halt_others_i(hoth), .other_halt_i(oth), .tx_done_i(txdone),
		.online_o(online), .end_of_seq_o(eos), .end_of_tx_o(eot)
	);

	initial begin
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (stp === 1'b1) begin
			n_step++;
		end
	end

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic tick(int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// Setup, then access held until pready is sampled high
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (prdy !== 1'b1);
		rd = prd;
		err = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		chk("pready wait", 32'h0000_0001, k);
	endtask : apb

	task automatic rdchk(logic [7:0] a, logic [31:0] e, string n);
		apb(1'b0, a, 32'h0000_0000);
		chk(n, e, rd);
	endtask : rdchk

	// Switch held long enough to pass the synchroniser
	task automatic press(int i);
		tick(1);
		sw[i] <= 1'b1;
		tick(6);
		sw[i] <= 1'b0;
		tick(6);
	endtask : press

	task automatic tend(string n);
		$display("test %s done", n);
	endtask : tend

	initial begin
		tick(30000);
		n_fail++;
		print_verdict();
	end

	initial begin
		tick(4);
		rst_n <= 1'b1;
		tick(4);
		chk("lamps", 9'h000, lamp);
		chk("bid_req", 1'b0, req);
		chk("level", 4'h8, lvl);
		rdchk(tsp_pkg::CFG_OFF, tsp_pkg::CFG_RST, "cfg");
		rdchk(tsp_pkg::STAT_OFF, 32'h0000_0000, "status");
		apb(1'b1, 8'h0c, 32'hffff_ffff);
		chk("wr slverr", 1'b1, err);
		apb(1'b1, tsp_pkg::STAT_OFF, 32'h0000_ffff);
		rdchk(tsp_pkg::STAT_OFF, 32'h0000_0000, "status ro");
		rdchk(8'h0c, 32'h0000_0000, "unmapped");
		chk("rd slverr", 1'b1, err);
		tend("registers");
		for (int l = 0; l < 4; l++) begin
			v = l | 32'h0000_00a0 | (l[0] << tsp_pkg::CFG_SYNC_BIT);
			v = v | ((32'h15 ^ l) << tsp_pkg::CFG_HDR_LSB) | 32'hc0c0_0c0c;
			apb(1'b1, tsp_pkg::CFG_OFF, v);
			tick(2);
			chk("level", l + 5, lvl);
			chk("interval", 4'ha, uci);
			chk("sync", l[0], sync);
			chk("header", 5'h15 ^ l, hdr);
			rdchk(tsp_pkg::CFG_OFF, v & tsp_pkg::CFG_MASK, "cfg rd");
		end
		tend("settings");
		txd <= 1'b1;
		tick(8);
		chk("line", 1'b1, lpos);
		txd <= 1'b0;
		tick(8);
		chk("line", 1'b0, lpos);
		abn <= 1'b1;
		tick(8);
		chk("abnormal", 1'b1, lamp[5]);
		abn <= 1'b0;
		tick(8);
		chk("abnormal", 1'b0, lamp[5]);
		for (int i = 0; i < 3; i++) begin
			alm[i] <= 1'b1;
			tick(8);
			alm[i] <= 1'b0;
			tick(8);
			chk("alarms", (2 << i) - 1, lamp[8:6]);
		end
		press(5);
		chk("alarms", 3'h0, lamp[8:6]);
		alm[1] <= 1'b1;
		tick(8);
		alm[1] <= 1'b0;
		apb(1'b1, tsp_pkg::CMD_OFF, 32'h0000_0001);
		tick(4);
		chk("alarm cmd", 3'h0, lamp[8:6]);
		tend("lamps");
		s = n_step;
		press(1);
		chk("steps", s, n_step);
		press(0);
		chk("halt lamp", 1'b1, lamp[0]);
		chk("halt others", 1'b1, hoth);
		press(1);
		press(1);
		chk("steps", s + 2, n_step);
		press(0);
		chk("halt lamp", 1'b0, lamp[0]);
		chk("halt others", 1'b0, hoth);
		press(3);
		chk("suppress", 1'b1, lamp[3]);
		chk("skip", 1'b1, skip);
		txdone <= 1'b1;
		tick(3);
		txdone <= 1'b0;
		tick(8);
		chk("suppress", 1'b0, lamp[3]);
		chk("skip", 1'b0, skip);
		tend("halt step delete");
		press(2);
		tick(30);
		chk("bid no tape", 2'b00, {lamp[2], req});
		tape <= 1'b1;
		tick(8);
		press(2);
		chk("motor", 1'b1, mrun);
		chk("bid early", 2'b10, {lamp[2], req});
		press(2);
		tick(30);
		chk("cancel", 3'h0, {lamp[2], req, mrun});
		press(2);
		tick(28);
		chk("bid_req", 1'b1, req);
		chk("online", 2'b11, {lamp[1], run});
		press(2);
		chk("bid kept", 1'b1, lamp[2]);
		press(0);
		chk("run halted", 1'b0, run);
		s = n_step;
		press(1);
		chk("steps", s + 1, n_step);
		press(0);
		chk("run resumed", 1'b1, run);
		s = n_step;
		spul <= 1'b1;
		tick(6);
		spul <= 1'b0;
		tick(6);
		chk("pulse step", s + 1, n_step);
		oth <= 1'b1;
		tick(8);
		chk("other halt", 1'b0, run);
		oth <= 1'b0;
		tape <= 1'b0;
		tick(8);
		chk("tape out", 1'b1, lamp[2]);
		t = 0;
		while (lamp[2] !== 1'b0 && t < 600) begin
			tick(1);
			t++;
		end
		tick(4);
		chk("seq end", 3'h0, {lamp[2], req, mrun});
		tick(12);
		chk("offline", 1'b0, lamp[1]);
		tend("bid");
		press(4);
		chk("manual motor", 2'b11, {lamp[4], mrun});
		tend("motor");
		press(0);
		press(3);
		chk("pre reset", 3'h7, {lamp[0], lamp[3], lamp[4]});
		rst_n <= 1'b0;
		tick(4);
		rst_n <= 1'b1;
		tick(4);
		chk("reset lamps", 9'h000, lamp);
		chk("reset outs", 4'h0, {req, mrun, hoth, skip});
		rdchk(tsp_pkg::CFG_OFF, tsp_pkg::CFG_RST, "cfg reset");
		tend("reset");
		print_verdict();
	end
endmodule : tb_tape_sender_panel_control

`default_nettype wire
